// ==== kwu_pkg.sv ====
/*
  constants for the key wake-up edge flag block: register offsets, reset
  values and filter timing. assumes a 100 MHz system clock.
*/
package kwu_pkg;
  // register offsets on the 8-bit register port
  localparam logic [7:0] OFS_IRQ_EN_J   = 8'h2C; // wake_irq_enable_port_j
  localparam logic [7:0] OFS_IRQ_EN_H   = 8'h2D; // wake_irq_enable_port_h
  localparam logic [7:0] OFS_FLAGS_J    = 8'h2E; // wake_flags_port_j
  localparam logic [7:0] OFS_FLAGS_H    = 8'h2F; // wake_flags_port_h
  localparam logic [7:0] OFS_POLARITY_J = 8'h30; // edge_polarity_port_j
  localparam logic [7:0] OFS_POLARITY_H = 8'h31; // edge_polarity_port_h
  // reset values
  localparam logic [7:0] RST_IRQ_EN     = 8'h00;
  localparam logic [7:0] RST_FLAGS      = 8'h00;
  localparam logic [7:0] RST_POLARITY   = 8'h00;
  localparam logic [7:0] RD_UNMAPPED    = 8'h00;
  // clock and filter oscillator timing
  localparam int         CLK_PERIOD_NS  = 10;
  localparam int         FILT_OSC_NS    = 300; // filter oscillator period
  localparam int         FILT_PER_INT   = FILT_OSC_NS / CLK_PERIOD_NS;
  localparam logic [4:0] FILT_LAST      = 5'(FILT_PER_INT - 1);
  // three sample points, spread over one oscillator period
  localparam logic [4:0] FILT_SMP_A     = 5'(FILT_PER_INT / 6);
  localparam logic [4:0] FILT_SMP_B     = 5'(FILT_PER_INT / 2);
  localparam logic [4:0] FILT_SMP_C     = 5'((FILT_PER_INT * 5) / 6);
  localparam logic [1:0] FILT_VOTE_MIN  = 2'h2; // two of three samples
  // filter states
  typedef enum logic [1:0] {
    KWU_FLT_IDLE = 2'b01,
    KWU_FLT_RUN  = 2'b10
  } kwu_flt_state_e;
endpackage : kwu_pkg

// ==== kwu_filt_if.sv ====
/*
  carrier between the flag logic and the shared stop-mode glitch filter.
  assumes both ends run on clk_sys.
*/
`timescale 1ns/10ps
`default_nettype none
interface kwu_filt_if;
  logic trig;    // any enabled pin at its triggering level
  logic start;   // triggering edge seen while in stop
  logic valid;   // one-cycle pulse: majority vote accepted the level
  logic running; // filter oscillator is running
  modport ctl (output trig, output start, input valid, input running);
  modport flt (input trig, input start, output valid, output running);
endinterface : kwu_filt_if
`default_nettype wire

// ==== kwu_vote_filter.sv ====
/*
  shared glitch filter: an oscillator model and a three-sample majority
  vote. assumes trig is already synchronous to clk_sys.
*/
`timescale 1ns/10ps
`default_nettype none
module kwu_vote_filter (
  input  wire logic clk_sys,
  input  wire logic sys_rst,
  kwu_filt_if.flt   fi
);
  import kwu_pkg::*;

  kwu_flt_state_e state;     // idle or oscillating
  logic [4:0]     cnt;       // position inside the oscillator period
  logic [1:0]     votes;     // samples seen at triggering level
  logic           valid_q;   // accepted pulse
  wire            smp_pt   = (cnt == FILT_SMP_A) || (cnt == FILT_SMP_B)
                             || (cnt == FILT_SMP_C);
  wire            per_end  = (cnt == FILT_LAST);
  wire            smp_hit  = smp_pt && fi.trig;
  wire [1:0]      votes_n  = votes + {1'b0, smp_hit};
  wire            vote_ok  = votes_n >= FILT_VOTE_MIN;

  assign fi.valid   = valid_q;
  assign fi.running = (state == KWU_FLT_RUN);

  // oscillator sequencing; keeps running while each period votes valid
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state   <= KWU_FLT_IDLE;
      cnt     <= 5'h00;
      votes   <= 2'h0;
      valid_q <= 1'b0;
    end else begin
      valid_q <= 1'b0;
      unique case (state)
        KWU_FLT_IDLE: begin
          cnt   <= 5'h00;
          votes <= 2'h0;
          if (fi.start) begin                         // [R9]
            state <= KWU_FLT_RUN;
          end
        end
        KWU_FLT_RUN: begin
          if (per_end) begin
            cnt     <= 5'h00;
            votes   <= 2'h0;
            valid_q <= vote_ok;                       // [R10] [R11]
            // a short gap between pulses is outvoted and never stops it
            if (!vote_ok) begin                       // [R12]
              state <= KWU_FLT_IDLE;
            end
          end else begin
            cnt   <= cnt + 5'h01;
            votes <= votes_n;
          end
        end
      endcase
    end
  end

  // checks of the filter
  chk_filter_start: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (state == KWU_FLT_IDLE && fi.start) |=> fi.running) // [R9]
    else $error("filter did not start on a triggering edge");

  chk_vote_valid: assert property (@(posedge clk_sys) disable iff (sys_rst)
    valid_q |-> $past(per_end && votes_n >= FILT_VOTE_MIN)) // [R10]
    else $error("filter accepted a level without two samples");
endmodule : kwu_vote_filter
`default_nettype wire

// ==== kwu_top.sv ====
/*
  key wake-up edge flags for two 8-bit ports, j and h, with a shared
  stop-mode glitch filter and one wake-up interrupt. assumes pins and
  register strobes are synchronous to clk_sys.
  // Overview of operation
  // R1 - active edge on pin sets its flag
  // R2 - writing one clears a flag, zero ignored
  // R3 - polarity 0: falling edge active, pull-up on
  // R4 - polarity 1: rising edge active, pull-down on
  // R5 - polarity change may itself set the flag
  // R6 - software sets polarity before clearing flags
  // R7 - flag and enable both set request interrupt
  // R8 - glitch filter only in stop, else bypassed
  // R9 - enabled triggering edge starts filter oscillator
  // R10 - two of three samples accept the level
  // R11 - one filter shared by all enabled pins
  // R12 - close pulses may merge into one
  // R13 - all sixteen pins share one interrupt
  // R14 - unclocked wake path from enabled pins in stop
  // R15 - works whether pin is input or output
  // R16 - synchronise pins, compare with previous sample
*/
// Implementation choice: strobed register access.
`timescale 1ns/10ps
`default_nettype none
module kwu_top (
  input  wire logic       clk_sys,
  input  wire logic       sys_rst,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic [7:0] pin_j_in,
  input  wire logic [7:0] pin_h_in,
  input  wire logic       stop_mode,
  output logic            wake_irq,
  output logic            wake_async,
  output logic      [7:0] pull_up_en_j,
  output logic      [7:0] pull_up_en_h,
  output logic      [7:0] pull_dn_en_j,
  output logic      [7:0] pull_dn_en_h
);
  import kwu_pkg::*;

  kwu_filt_if fif ();                   // link to the shared filter

  logic [7:0] en_j;                     // wake_irq_enable_port_j
  logic [7:0] en_h;                     // wake_irq_enable_port_h
  logic [7:0] flags_j;                  // wake_flags_port_j
  logic [7:0] flags_h;                  // wake_flags_port_h
  logic [7:0] pol_j;                    // edge_polarity_port_j
  logic [7:0] pol_h;                    // edge_polarity_port_h
  logic [7:0] sy1_j;                    // synchroniser first stage
  logic [7:0] sy1_h;
  logic [7:0] sy2_j;                    // synchroniser second stage
  logic [7:0] sy2_h;
  logic [7:0] act_prev_j;               // previous triggering level
  logic [7:0] act_prev_h;
  logic       trig_prev;                // previous enabled trigger level
  logic [7:0] next_flags_j;
  logic [7:0] next_flags_h;

  // register port decode
  wire wr_ej  = reg_wr && (reg_addr == OFS_IRQ_EN_J);
  wire wr_eh  = reg_wr && (reg_addr == OFS_IRQ_EN_H);
  wire wr_ifj = reg_wr && (reg_addr == OFS_FLAGS_J);
  wire wr_ifh = reg_wr && (reg_addr == OFS_FLAGS_H);
  wire wr_pj  = reg_wr && (reg_addr == OFS_POLARITY_J);
  wire wr_ph  = reg_wr && (reg_addr == OFS_POLARITY_H);

  // a pin is at its triggering level when it matches the polarity bit;
  // direction is not looked at, so driven outputs still wake [R15]
  wire [7:0] act_j = ~(sy2_j ^ pol_j);  // [R3] [R4]
  wire [7:0] act_h = ~(sy2_h ^ pol_h);  // [R3] [R4]

  // edge = level became triggering since last sample; a polarity write
  // flips act and so may look like an edge [R5] [R16]
  wire [7:0] edge_j = act_j & ~act_prev_j;
  wire [7:0] edge_h = act_h & ~act_prev_h;

  // one trigger into the shared filter from all enabled pins [R11]
  wire       trig_any = |(act_j & en_j) | |(act_h & en_h);

  // outside stop edges set flags directly; in stop only the filter does
  wire [7:0] set_j = stop_mode ? (fif.valid ? (act_j & en_j) : 8'h00)
                               : edge_j;            // [R1] [R8]
  wire [7:0] set_h = stop_mode ? (fif.valid ? (act_h & en_h) : 8'h00)
                               : edge_h;            // [R1] [R8]

  // write-one-to-clear; a set in the same cycle wins over the clear
  wire [7:0] clr_j = wr_ifj ? reg_wdata : 8'h00;    // [R2]
  wire [7:0] clr_h = wr_ifh ? reg_wdata : 8'h00;    // [R2]
  assign next_flags_j = (flags_j & ~clr_j) | set_j;
  assign next_flags_h = (flags_h & ~clr_h) | set_h;

  // read data selection
  wire [7:0] rd_mux =
    (reg_addr == OFS_IRQ_EN_J)   ? en_j    :
    (reg_addr == OFS_IRQ_EN_H)   ? en_h    :
    (reg_addr == OFS_FLAGS_J)    ? flags_j :
    (reg_addr == OFS_FLAGS_H)    ? flags_h :
    (reg_addr == OFS_POLARITY_J) ? pol_j   :
    (reg_addr == OFS_POLARITY_H) ? pol_h   : RD_UNMAPPED;

  // filter hookup: start on a fresh enabled trigger while in stop
  assign fif.trig  = trig_any;
  assign fif.start = stop_mode && trig_any && !trig_prev; // [R9]

  kwu_vote_filter u_filter (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .fi      (fif)
  );

  // unclocked wake path: models the asynchronous route out of stop,
  // the only output that is not registered [R14]
  assign wake_async = stop_mode && trig_any;

  // pin synchroniser; first stage feeds only the second [R16]
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      sy1_j <= 8'h00;
      sy1_h <= 8'h00;
      sy2_j <= 8'h00;
      sy2_h <= 8'h00;
    end else begin
      sy1_j <= pin_j_in;
      sy1_h <= pin_h_in;
      sy2_j <= sy1_j;
      sy2_h <= sy1_h;
    end
  end

  // previous levels for edge detection; reset to triggering so that a
  // pin resting low with falling polarity gives no flag out of reset
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      act_prev_j <= 8'hFF;
      act_prev_h <= 8'hFF;
      trig_prev  <= 1'b0;
    end else begin
      act_prev_j <= act_j;
      act_prev_h <= act_h;
      trig_prev  <= trig_any;
    end
  end

  // configuration registers
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      en_j  <= RST_IRQ_EN;
      en_h  <= RST_IRQ_EN;
      pol_j <= RST_POLARITY;
      pol_h <= RST_POLARITY;
    end else begin
      if (wr_ej) en_j <= reg_wdata;
      if (wr_eh) en_h <= reg_wdata;
      if (wr_pj) pol_j <= reg_wdata;
      if (wr_ph) pol_h <= reg_wdata;
    end
  end

  // wake-up flags
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      flags_j <= RST_FLAGS;
      flags_h <= RST_FLAGS;
    end else begin
      flags_j <= next_flags_j;          // [R1] [R2]
      flags_h <= next_flags_h;          // [R1] [R2]
    end
  end

  // registered outputs: interrupt, pulls, read data
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      wake_irq     <= 1'b0;
      pull_up_en_j <= 8'hFF;
      pull_up_en_h <= 8'hFF;
      pull_dn_en_j <= 8'h00;
      pull_dn_en_h <= 8'h00;
      reg_rdata    <= RD_UNMAPPED;
    end else begin
      // sixteen sources, one request [R7] [R13]
      wake_irq     <= |(flags_j & en_j) | |(flags_h & en_h);
      pull_up_en_j <= ~pol_j;           // [R3]
      pull_up_en_h <= ~pol_h;           // [R3]
      pull_dn_en_j <= pol_j;            // [R4]
      pull_dn_en_h <= pol_h;            // [R4]
      reg_rdata    <= reg_rd ? rd_mux : RD_UNMAPPED;
    end
  end

  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  sequence s_fall_j0;
    !stop_mode && !pol_j[0] && sy2_j[0]
      ##1 !stop_mode && !pol_j[0] && !sy2_j[0];
  endsequence
  sequence s_rise_h0;
    !stop_mode && pol_h[0] && !sy2_h[0]
      ##1 !stop_mode && pol_h[0] && sy2_h[0];
  endsequence

  chk_fall_sets_flag: assert property ( // [R3]
    s_fall_j0 |-> ##1 (flags_j[0] || $past(wr_ifj)))
    else $error("falling edge did not set port j flag");

  chk_rise_sets_flag: assert property ( // [R4]
    s_rise_h0 |-> ##1 (flags_h[0] || $past(wr_ifh)))
    else $error("rising edge did not set port h flag");

  chk_flag_set: assert property ( // [R1]
    (|set_j) |=> ((flags_j & $past(set_j)) == $past(set_j)))
    else $error("flag not set after active edge");

  chk_flag_clear: assert property ( // [R2]
    (|($past(flags_j) & ~flags_j)) |-> ($past(wr_ifj)
      && (($past(flags_j) & ~flags_j & ~$past(reg_wdata)) == 8'h00)))
    else $error("flag cleared without a write of one");

  chk_irq_request: assert property ( // [R7]
    (|(flags_j & en_j) || |(flags_h & en_h)) |=> wake_irq)
    else $error("enabled flag did not raise the interrupt");

  chk_irq_quiet: assert property ( // [R13]
    !(|(flags_j & en_j) || |(flags_h & en_h)) |=> !wake_irq)
    else $error("interrupt without an enabled flag");

  chk_stop_bypass: assert property ( // [R8]
    (stop_mode && !fif.valid) |=>
      ((flags_j & ~$past(flags_j)) == 8'h00
       && (flags_h & ~$past(flags_h)) == 8'h00))
    else $error("flag set in stop without the filter");

  chk_pull_select: assert property ( // [R3] [R4]
    $changed(pol_j) |=> (pull_dn_en_j == $past(pol_j)
      && pull_up_en_j == ~$past(pol_j)))
    else $error("pull selection does not follow polarity");

  chk_async_wake: assert property ( // [R14]
    wake_async == (stop_mode && (|((sy2_j ~^ pol_j) & en_j)
                                 || |((sy2_h ~^ pol_h) & en_h))))
    else $error("no unclocked wake path in stop");

  chk_read_data: assert property (
    (reg_rd && reg_addr == OFS_POLARITY_J) |=> reg_rdata == $past(pol_j))
    else $error("polarity read back wrong");
endmodule : kwu_top
`default_nettype wire

// ==== kwu_keys.sv ====
/*
  external key lines of one 8-bit port. assumes the bench picks the
  driven pins and the block supplies the pull enables.
*/
`timescale 1ns/10ps
`default_nettype none
module kwu_keys (
  input  wire logic       clk_sys,
  input  wire logic [7:0] drv_en,     // 1 = key holds the line
  input  wire logic [7:0] drv_val,    // level held by the key
  input  wire logic [7:0] pull_up_en, // pull-up from the block
  input  wire logic [7:0] pull_dn_en, // pull-down from the block
  output logic      [7:0] pin         // resolved line level
);
  logic [7:0] last; // previous level of each line
  // a floating line with no pull must not look stable, so it toggles
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (drv_en[i]) pin[i] = drv_val[i];
      else if (pull_up_en[i]) pin[i] = 1'b1;
      else if (pull_dn_en[i]) pin[i] = 1'b0;
      else pin[i] = ~last[i];
    end
  end
  // remember the line level once per cycle
  always_ff @(posedge clk_sys) begin
    last <= pin;
  end
endmodule : kwu_keys
`default_nettype wire

// ==== kwu_top_tb.sv ====
/*
  self-checking bench for the key wake-up flag block. assumes the
  design package and interface are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
module kwu_top_tb;
  import kwu_pkg::*;
  logic       clk_sys;
  logic       sys_rst;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_rdata;
  logic [7:0] pin_j;
  logic [7:0] pin_h;
  logic       stop_mode;
  logic       wake_irq;
  logic       wake_async;
  logic [7:0] pu_j;
  logic [7:0] pu_h;
  logic [7:0] pd_j;
  logic [7:0] pd_h;
  logic [7:0] drv_en [2];  // key held per port
  logic [7:0] drv_val [2]; // key level per port
  logic [7:0] exp_q [$];   // expected read data, oldest first
  logic       rd_d;        // a read was taken at the last edge
  logic [7:0] pol, m, c, en, a_en, a_fl, a_po;
  int         err_total, n_compared, cyc, len;
  integer     seed = 32'hA4476009;

  kwu_top u_dut (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_j_in(pin_j),
    .pin_h_in(pin_h), .stop_mode(stop_mode), .wake_irq(wake_irq),
    .wake_async(wake_async), .pull_up_en_j(pu_j), .pull_up_en_h(pu_h),
    .pull_dn_en_j(pd_j), .pull_dn_en_h(pd_h));
  kwu_keys u_keys_j (.clk_sys(clk_sys), .drv_en(drv_en[0]),
    .drv_val(drv_val[0]), .pull_up_en(pu_j), .pull_dn_en(pd_j),
    .pin(pin_j));
  kwu_keys u_keys_h (.clk_sys(clk_sys), .drv_en(drv_en[1]),
    .drv_val(drv_val[1]), .pull_up_en(pu_h), .pull_dn_en(pd_h),
    .pin(pin_h));

  // 100 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask : chk

  task automatic conclude;
    if (err_total == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : conclude

  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : idle

  // one-cycle write; a spare edge keeps strobes from being set twice
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    @(posedge clk_sys);
  endtask : wr

  // one-cycle read; the monitor compares the data a cycle later
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    exp_q.push_back(exp);
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(posedge clk_sys);
  endtask : rd

  // read data stand only in the cycle after the strobe; also the timeout
  always @(posedge clk_sys) begin
    if (rd_d) chk(reg_rdata, exp_q.pop_front());
    rd_d <= reg_rd;
    cyc  <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      conclude();
    end
  end

  // main sequence: reset, then per-port edges, then the stop filter
  initial begin
    sys_rst = 1'b1; reg_addr = 8'h00; reg_wdata = 8'h00;
    reg_wr = 1'b0; reg_rd = 1'b0; stop_mode = 1'b0; rd_d = 1'b0;
    drv_en = '{8'h00, 8'h00}; drv_val = '{8'h00, 8'h00}; cyc = 0;
    repeat (16) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    for (int i = 0; i < 6; i++) rd(OFS_IRQ_EN_J + 8'(i), 8'h00);
    wr(8'h40, 8'hFF); // unmapped: ignored
    rd(8'h40, RD_UNMAPPED);
    for (int p = 0; p < 2; p++) begin
      a_en = p ? OFS_IRQ_EN_H : OFS_IRQ_EN_J;
      a_fl = p ? OFS_FLAGS_H : OFS_FLAGS_J;
      a_po = p ? OFS_POLARITY_H : OFS_POLARITY_J;
      pol = 8'($random(seed));
      wr(a_po, pol);
      idle(6);
      wr(a_fl, 8'hFF);
      rd(a_po, pol);
      @(negedge clk_sys);
      chk(p ? pu_h : pu_j, ~pol);
      chk(p ? pd_h : pd_j, pol);
      @(posedge clk_sys);
      // keys pull chosen lines to their active level, then let go
      m = 8'($random(seed));
      drv_val[p] <= pol;
      drv_en[p]  <= m;
      idle(5);
      drv_en[p] <= 8'h00;
      idle(6);
      rd(a_fl, m);
      c = 8'($random(seed));
      wr(a_fl, c);
      wr(a_fl, 8'h00);
      rd(a_fl, m & ~c);
      en = 8'($random(seed));
      wr(a_en, en);
      rd(a_en, en);
      idle(2);
      @(negedge clk_sys);
      chk({7'h00, wake_irq}, {7'h00, |(m & ~c & en)});
      @(posedge clk_sys);
      wr(a_fl, 8'hFF);
      idle(2);
      @(negedge clk_sys);
      chk({7'h00, wake_irq}, 8'h00);
      @(posedge clk_sys);
    end
    // stop: a short glitch is voted out, a long pulse is accepted
    wr(OFS_POLARITY_J, 8'h00);
    wr(OFS_IRQ_EN_J, 8'h01);
    idle(6);
    wr(OFS_FLAGS_J, 8'hFF);
    stop_mode  <= 1'b1;
    drv_val[0] <= 8'h00;
    for (int k = 0; k < 2; k++) begin
      len = k ? 40 : 4;
      drv_en[0] <= 8'h01;
      idle(2);
      @(negedge clk_sys);
      chk({7'h00, wake_async}, 8'h01);
      @(posedge clk_sys);
      idle(len - 3);
      drv_en[0] <= 8'h00;
      idle(45);
      rd(OFS_FLAGS_J, 8'(k));
    end
    @(negedge clk_sys);
    chk({7'h00, wake_irq}, 8'h01);
    @(posedge clk_sys);
    // outside stop the same short glitch sets the flag directly
    stop_mode <= 1'b0;
    wr(OFS_FLAGS_J, 8'hFF);
    drv_en[0] <= 8'h01;
    idle(4);
    drv_en[0] <= 8'h00;
    idle(6);
    rd(OFS_FLAGS_J, 8'h01);
    idle(2);
    conclude();
  end
endmodule : kwu_top_tb
`default_nettype wire
